// ### verilog/mac_slice.sv
// Multiply-accumulate slice: pre-adder, multiplier, SIMD adder, logic unit, detector.
`timescale 1ns/1ps
`default_nettype none
`include "mac_slice_defs.svh"
module mac_slice
   import mac_slice_pkg::*;
#(
   parameter bit IN_REG = 1'b1,     // Input register stage present.
   parameter bit MUL_REG = 1'b1,    // Product register stage present.
   parameter bit OUT_REG = 1'b1     // Result register drives the output (accumulate uses the held result either way).
) (
   input wire logic clk,                    // Clock, 25 MHz.
   input wire logic nrst,                   // Asynchronous reset, active low.
   input wire logic [24:0] a_in,            // Pre-adder operand, signed.
   input wire logic [24:0] d_in,            // Second pre-adder operand, signed.
   input wire logic [17:0] b_in,            // Multiplier operand, signed.
   input wire logic [47:0] c_in,            // Adder operand, signed.
   input wire logic [47:0] ab_in,           // Bypass operand replacing the product.
   input wire logic [47:0] pattern,         // Pattern to detect.
   input wire logic [47:0] pat_mask,        // High bits are ignored by the detector.
   input wire logic use_cascade,            // High takes the cascade input as adder operand.
   input wire logic [47:0] casc_in,         // Cascade input from the neighbour.
   input wire slice_ctrl_t ctrl,            // Operation controls.
   input wire logic ce_in,                  // Input stage clock enable.
   input wire logic ce_mul,                 // Product stage clock enable.
   input wire logic ce_out,                 // Result stage clock enable.
   input wire logic clr_in,                 // Input stage synchronous clear.
   input wire logic clr_mul,                // Product stage synchronous clear.
   input wire logic clr_out,                // Result stage synchronous clear.
   output logic [47:0] p_out,               // Result.
   output logic [47:0] casc_out,            // Cascade output to the neighbour.
   output pat_flags_t pat,                  // Pattern match flags.
   output logic wide_and                    // High when the pattern matches and the unmasked cascade input bits are all ones.
);
   // Parameters are bits, so every stage combination is served; the checks below refuse
   // constant widths that the fixed ports and the lane split cannot carry.
   generate
      if ((`MS_A_W + `MS_B_W) > `MS_P_W) begin : g_prod_fit
         $error("Product width exceeds the result width.");
      end
      if (((2 * `MS_LANE2_W) != `MS_P_W) || ((4 * `MS_LANE4_W) != `MS_P_W)) begin : g_lane_fit
         $error("Lane widths do not tile the result width.");
      end
   endgenerate

   // Input stage registers.
   logic [24:0] a_q;
   logic [24:0] d_q;
   logic [17:0] b_q;
   logic [47:0] c_q;
   logic [47:0] ab_q;
   slice_ctrl_t ctl1_q;
   // Selected values after the optional input stage.
   logic [24:0] a_s;
   logic [24:0] d_s;
   logic [17:0] b_s;
   logic [47:0] c_s;
   logic [47:0] ab_s;
   slice_ctrl_t ctl1_s;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         a_q <= 25'h0000000;
         d_q <= 25'h0000000;
         b_q <= 18'h00000;
         c_q <= `MS_RST_VAL;
         ab_q <= `MS_RST_VAL;
         ctl1_q <= '0;
      end else if (clr_in) begin
         a_q <= 25'h0000000;
         d_q <= 25'h0000000;
         b_q <= 18'h00000;
         c_q <= `MS_RST_VAL;
         ab_q <= `MS_RST_VAL;
         ctl1_q <= '0;
      end else if (ce_in) begin
         a_q <= a_in;
         d_q <= d_in;
         b_q <= b_in;
         c_q <= use_cascade ? casc_in : c_in;
         ab_q <= ab_in;
         ctl1_q <= ctrl;
      end
   end

   assign a_s = IN_REG ? a_q : a_in;
   assign d_s = IN_REG ? d_q : d_in;
   assign b_s = IN_REG ? b_q : b_in;
   assign c_s = IN_REG ? c_q : (use_cascade ? casc_in : c_in);
   assign ab_s = IN_REG ? ab_q : ab_in;
   assign ctl1_s = IN_REG ? ctl1_q : ctrl;

   // pre-adder sum
   // The sum keeps 25 bits; the caller keeps the two operands in range.
   logic [24:0] pre_sum;
   assign pre_sum = ctl1_s.pre_sub ? (d_s - a_s) : (d_s + a_s);

   logic signed [42:0] prod;
   assign prod = $signed(pre_sum) * $signed(b_s);
   logic [47:0] prod_x;
   assign prod_x = {{5{prod[42]}}, prod};

   logic [47:0] m_w;
   assign m_w = ctl1_s.bypass ? ab_s : prod_x;

   // Product stage registers.
   logic [47:0] m_q;
   logic [47:0] c2_q;
   slice_ctrl_t ctl2_q;
   logic [47:0] m_s;
   logic [47:0] c2_s;
   slice_ctrl_t ctl2_s;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         m_q <= `MS_RST_VAL;
         c2_q <= `MS_RST_VAL;
         ctl2_q <= '0;
      end else if (clr_mul) begin
         m_q <= `MS_RST_VAL;
         c2_q <= `MS_RST_VAL;
         ctl2_q <= '0;
      end else if (ce_mul) begin
         m_q <= m_w;
         c2_q <= c_s;
         ctl2_q <= ctl1_s;
      end
   end

   // Without the product stage the values pass straight through.
   assign m_s = MUL_REG ? m_q : m_w;
   assign c2_s = MUL_REG ? c2_q : c_s;
   assign ctl2_s = MUL_REG ? ctl2_q : ctl1_s;

   // Result register and adder operand choice.
   logic [47:0] p_q;
   logic acc_mode;
   logic cnt_mode;
   logic do_sub;
   logic [47:0] add_x;
   logic [47:0] add_y;
   logic [47:0] sum_w;
   logic [47:0] lu_w;
   logic [47:0] res_w;

   assign acc_mode = (ctl2_s.op == op_acc_add) || (ctl2_s.op == op_acc_sub);
   assign cnt_mode = (ctl2_s.op == op_cnt_up) || (ctl2_s.op == op_cnt_dn);
   assign do_sub = (ctl2_s.op == op_sub) || (ctl2_s.op == op_acc_sub) ||
                   (ctl2_s.op == op_cnt_dn);
   // Accumulate and count take the held result as first operand.
   assign add_x = (acc_mode || cnt_mode) ? p_q : c2_s;
   assign add_y = cnt_mode ? 48'h000000000001 : m_s;

   // Lane-splittable adder for add, subtract, accumulate and count.
   simd_adder u_add (
      .x(add_x),
      .y(add_y),
      .sub(do_sub),
      .simd(ctl2_s.simd),
      .sum(sum_w)
   );

   // Bitwise functions of the product path and the adder operand.
   logic_unit #(.W(`MS_P_W)) u_lu (
      .x(m_s),
      .y(c2_s),
      .fn(ctl2_s.fn),
      .res(lu_w)
   );

   // Logic operations take the logic result instead of the sum.
   assign res_w = (ctl2_s.op == op_logic) ? lu_w : sum_w;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         p_q <= `MS_RST_VAL;
      end else if (clr_out) begin
         p_q <= `MS_RST_VAL;
      end else if (ce_out) begin
         p_q <= res_w;
      end
   end

   assign p_out = OUT_REG ? p_q : res_w;
   assign casc_out = p_out;

   assign pat.match = &((p_out ~^ pattern) | pat_mask);
   assign pat.match_b = &((p_out ~^ ~pattern) | pat_mask);
   assign wide_and = pat.match & (&(casc_in | pat_mask));

   // Checks.
   // accumulate uses held value
   chk_acc_sum: assert property (@(posedge clk) disable iff (!nrst)
      (OUT_REG && ce_out && !clr_out && ctl2_s.op == op_acc_add && ctl2_s.simd == simd_one)
      |=> (p_q == $past(p_q) + $past(m_s))) else $error("accumulate sum wrong");
   chk_cnt_up: assert property (@(posedge clk) disable iff (!nrst)
      (OUT_REG && ce_out && !clr_out && ctl2_s.op == op_cnt_up && ctl2_s.simd == simd_one)
      |=> (p_q == $past(p_q) + 48'h000000000001)) else $error("count up wrong");
   chk_out_clear: assert property (@(posedge clk) disable iff (!nrst)
      clr_out |=> (p_q == 48'h000000000000)) else $error("clear failed");
   chk_out_hold: assert property (@(posedge clk) disable iff (!nrst)
      (!ce_out && !clr_out) |=> $stable(p_q)) else $error("hold failed");
   chk_mul_prod: assert property (@(posedge clk) disable iff (!nrst)
      !ctl1_s.bypass |-> ($signed(m_w) == $signed(pre_sum) * $signed(b_s)))
      else $error("product wrong");
   chk_bypass_pass: assert property (@(posedge clk) disable iff (!nrst)
      ctl1_s.bypass |-> (m_w == ab_s)) else $error("bypass wrong");
   chk_simd_lane: assert property (@(posedge clk) disable iff (!nrst)
      (ctl2_s.simd == simd_four && !do_sub) |->
      (sum_w[23:12] == add_x[23:12] + add_y[23:12])) else $error("lane carry leak");
   chk_pat_match: assert property (@(posedge clk) disable iff (!nrst)
      (pat.match == (((p_out ^ pattern) & ~pat_mask) == 48'h000000000000)))
      else $error("pattern flag wrong");
   chk_casc_out: assert property (@(posedge clk) disable iff (!nrst)
      (OUT_REG && ce_out && !clr_out) |=> (casc_out == $past(res_w)))
      else $error("cascade output wrong");

   chk_casc_in: assert property (@(posedge clk) disable iff (!nrst)
      (ce_in && !clr_in && use_cascade) |=> (c_q == $past(casc_in)))
      else $error("cascade input not taken");

   chk_in_clear: assert property (@(posedge clk) disable iff (!nrst)
      clr_in |=> (a_q == 25'h0000000 && b_q == 18'h00000 && ctl1_q == '0))
      else $error("input clear failed");

   chk_in_hold: assert property (@(posedge clk) disable iff (!nrst)
      (!ce_in && !clr_in) |=> ($stable(a_q) && $stable(c_q) && $stable(ctl1_q)))
      else $error("input hold failed");

   chk_mul_clear: assert property (@(posedge clk) disable iff (!nrst)
      clr_mul |=> (m_q == 48'h000000000000 && c2_q == 48'h000000000000))
      else $error("product clear failed");

   chk_mul_stage: assert property (@(posedge clk) disable iff (!nrst)
      (ce_mul && !clr_mul) |=> (m_q == $past(m_w) && c2_q == $past(c_s)))
      else $error("product stage wrong");

   chk_pre_add: assert property (@(posedge clk) disable iff (!nrst)
      (!ctl1_s.pre_sub && !ctl1_s.bypass) |->
      ($signed(m_w) == $signed(d_s + a_s) * $signed(b_s))) else $error("pre-add wrong");

   chk_cnt_dn: assert property (@(posedge clk) disable iff (!nrst)
      (ce_out && !clr_out && ctl2_s.op == op_cnt_dn && ctl2_s.simd == simd_one)
      |=> (p_q == $past(p_q) - 48'h000000000001)) else $error("count down wrong");

   chk_logic_xor: assert property (@(posedge clk) disable iff (!nrst)
      (ctl2_s.op == op_logic && ctl2_s.fn == lf_xor) |-> (res_w == (m_s ^ c2_s)))
      else $error("logic result wrong");

   chk_pat_inv: assert property (@(posedge clk) disable iff (!nrst)
      (pat.match_b == (((p_out ^ ~pattern) & ~pat_mask) == 48'h000000000000)))
      else $error("inverse pattern flag wrong");

   chk_wide_and: assert property (@(posedge clk) disable iff (!nrst)
      (wide_and == (pat.match && ((casc_in | pat_mask) == 48'hffffffffffff))))
      else $error("wide flag wrong");
endmodule
`default_nettype wire

// ### verilog/mac_slice_defs.svh
// Constants for the multiply-accumulate slice.
`ifndef MAC_SLICE_DEFS_SVH
`define MAC_SLICE_DEFS_SVH
`define MS_A_W 25
`define MS_B_W 18
`define MS_P_W 48
`define MS_LANE2_W 24
`define MS_LANE4_W 12
`define MS_RST_VAL 48'h000000000000
`endif

// ### verilog/mac_slice_pkg.sv
// Types shared by the multiply-accumulate slice files.
package mac_slice_pkg;
   // Arithmetic operations of the adder stage, and the logic unit select.
   typedef enum logic [2:0] {
      op_add = 3'h0,
      op_sub = 3'h1,
      op_acc_add = 3'h2,
      op_acc_sub = 3'h3,
      op_cnt_up = 3'h4,
      op_cnt_dn = 3'h5,
      op_logic = 3'h6
   } alu_op_t;
   // Lane split of the 48-bit adder.
   typedef enum logic [1:0] {
      simd_one = 2'h0,
      simd_two = 2'h1,
      simd_four = 2'h2
   } simd_t;
   // Ten bitwise functions of the logic unit.
   typedef enum logic [3:0] {
      lf_and = 4'h0,
      lf_or = 4'h1,
      lf_xor = 4'h2,
      lf_nand = 4'h3,
      lf_nor = 4'h4,
      lf_xnor = 4'h5,
      lf_andn = 4'h6,
      lf_orn = 4'h7,
      lf_nota = 4'h8,
      lf_passx = 4'h9
   } logic_fn_t;
   // Per-cycle operation controls presented with the operands.
   typedef struct packed {
      logic bypass;
      logic pre_sub;
      alu_op_t op;
      simd_t simd;
      logic_fn_t fn;
   } slice_ctrl_t;
   // Pattern detector outputs.
   typedef struct packed {
      logic match;
      logic match_b;
   } pat_flags_t;
endpackage

// ### verilog/simd_adder.sv
// Lane-splittable 48-bit adder with no carry between lanes.
`timescale 1ns/1ps
`default_nettype none
`include "mac_slice_defs.svh"
module simd_adder
   import mac_slice_pkg::*;
(
   input wire logic [47:0] x,     // First operand.
   input wire logic [47:0] y,     // Second operand.
   input wire logic sub,          // High subtracts y from x.
   input wire simd_t simd,        // Lane split.
   output logic [47:0] sum        // Lane-wise result.
);
   // Four 12-bit segments; a carry crosses a segment edge only when lanes join there.
   logic [4:0] cy;
   logic [47:0] yy;
   assign yy = sub ? ~y : y;
   assign cy[0] = sub;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : seg
         logic [12:0] s;
         logic join_w;
         assign s = {1'b0, x[g*12 +: 12]} + {1'b0, yy[g*12 +: 12]} + {12'h000, cy[g]};
         assign sum[g*12 +: 12] = s[11:0];
         assign join_w = (simd == simd_one) || ((simd == simd_two) && (g == 0 || g == 2));
         assign cy[g+1] = join_w ? s[12] : sub;
      end
   endgenerate
endmodule
`default_nettype wire

// ### verilog/logic_unit.sv
// Bitwise logic unit with ten selectable functions.
`timescale 1ns/1ps
`default_nettype none
module logic_unit
   import mac_slice_pkg::*;
#(
   parameter int W = 48                // Operand width.
) (
   input wire logic [W-1:0] x,         // First operand.
   input wire logic [W-1:0] y,         // Second operand.
   input wire logic_fn_t fn,           // Function select.
   output logic [W-1:0] res            // Function result.
);
   // A zero-width operand cannot be served.
   generate
      if (W < 1) begin : g_bad_w
         $error("Operand width must be at least one bit.");
      end
   endgenerate
   assign res = (fn == lf_and) ? (x & y) :
                (fn == lf_or) ? (x | y) :
                (fn == lf_xor) ? (x ^ y) :
                (fn == lf_nand) ? ~(x & y) :
                (fn == lf_nor) ? ~(x | y) :
                (fn == lf_xnor) ? ~(x ^ y) :
                (fn == lf_andn) ? (x & ~y) :
                (fn == lf_orn) ? (x | ~y) :
                (fn == lf_nota) ? ~x : x;
endmodule
`default_nettype wire

// ### tb/fabric_model.sv
// Fabric model that drives the operands and controls of the slice.
`timescale 1ns/1ps
`default_nettype none
module fabric_model
   import mac_slice_pkg::*;
(
   input wire logic clk,          // Slice clock.
   output logic [24:0] a_in,      // Pre-adder operand.
   output logic [24:0] d_in,      // Second pre-adder operand.
   output logic [17:0] b_in,      // Multiplier operand.
   output logic [47:0] c_in,      // Adder operand.
   output logic [47:0] ab_in,     // Bypass operand.
   output logic [47:0] pattern,   // Detector pattern.
   output logic [47:0] pat_mask,  // Detector mask.
   output logic use_cascade,      // Cascade select.
   output logic [47:0] casc_in,   // Cascade word.
   output slice_ctrl_t ctrl,      // Operation controls.
   output logic [2:0] ce,         // Enables: in, mul, out.
   output logic [2:0] clr         // Clears: in, mul, out.
);
   // Everything idles at zero with all stages enabled.
   initial begin
      {a_in, d_in, b_in, c_in, ab_in, pattern, pat_mask, casc_in} = '0;
      use_cascade = 1'b0;
      ctrl = '0;
      ce = 3'h7;
      clr = 3'h0;
   end
   // controls with operands
   // Operands and their controls change together after a falling edge.
   task automatic put(input logic [24:0] a, d, input logic [17:0] b,
                      input logic [47:0] c, ab, input slice_ctrl_t k);
      @(negedge clk);
      a_in = a;
      d_in = d;
      b_in = b;
      c_in = c;
      ab_in = ab;
      ctrl = k;
   endtask
   // Detector and cascade inputs change after a falling edge.
   task automatic side(input logic [47:0] pt, mk, cs, input logic uc);
      @(negedge clk);
      pattern = pt;
      pat_mask = mk;
      casc_in = cs;
      use_cascade = uc;
   endtask
   // Stage enables and clears change after a falling edge.
   task automatic stage(input logic [2:0] e, r);
      @(negedge clk);
      ce = e;
      clr = r;
   endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the multiply-accumulate slice.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(g, e)
module testbench
   import mac_slice_pkg::*;
;
   logic clk;
   logic nrst;
   logic [24:0] a_in;
   logic [24:0] d_in;
   logic [17:0] b_in;
   logic [47:0] c_in;
   logic [47:0] ab_in;
   logic [47:0] pattern;
   logic [47:0] pat_mask;
   logic use_cascade;
   logic [47:0] casc_in;
   slice_ctrl_t ctrl;
   logic [2:0] ce;
   logic [2:0] clr;
   logic [47:0] p_out;
   logic [47:0] casc_out;
   pat_flags_t pat;
   logic wide_and;
   int error_cnt;
   int tests_run;
   localparam logic [47:0] LX = 48'h0f0f0f0f0f0f;
   localparam logic [47:0] LY = 48'h333333333333;

   fabric_model u_fabric_model(.clk, .a_in, .d_in, .b_in, .c_in, .ab_in, .pattern,
      .pat_mask, .use_cascade, .casc_in, .ctrl, .ce, .clr);
   mac_slice u_mac_slice(.clk, .nrst, .a_in, .d_in, .b_in, .c_in, .ab_in, .pattern,
      .pat_mask, .use_cascade, .casc_in, .ctrl, .ce_in(ce[2]), .ce_mul(ce[1]),
      .ce_out(ce[0]), .clr_in(clr[2]), .clr_mul(clr[1]), .clr_out(clr[0]), .p_out,
      .casc_out, .pat, .wide_and);

   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Counts a comparison and reports a mismatch.
   task automatic check(input logic [47:0] g, input logic [47:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // One clock edge, then let outputs settle.
   task automatic tick;
      @(posedge clk);
      #5;
   endtask
   // Issues one operation and waits out the three-stage latency.
   task automatic go(input logic [24:0] a, d, input logic [17:0] b,
                     input logic [47:0] c, ab, input slice_ctrl_t k);
      u_fabric_model.put(a, d, b, c, ab, k);
      repeat (3) tick();
   endtask
   function automatic slice_ctrl_t mk(logic by, logic ps, alu_op_t op, simd_t sm,
                                       logic_fn_t fn);
      return '{by, ps, op, sm, fn};
   endfunction
   // Multiply through the pre-adder, then add or subtract from c.
   task automatic mul_case(input logic [24:0] a, d, input logic [17:0] b,
                           input logic ps, input logic [47:0] c, input logic sb);
      logic signed [24:0] s;
      logic signed [47:0] pr;
      s = ps ? d - a : d + a;
      pr = s * $signed(b);
      go(a, d, b, c, 48'h0, mk(1'b0, ps, alu_op_t'(sb ? op_sub : op_add), simd_one, lf_and));
      `CHK(p_out, sb ? c - pr : c + pr);
   endtask
   function automatic logic [47:0] lexp(int i);
      case (i)
         0: return LX & LY;
         1: return LX | LY;
         2: return LX ^ LY;
         3: return ~(LX & LY);
         4: return ~(LX | LY);
         5: return ~(LX ^ LY);
         6: return LX & ~LY;
         7: return LX | ~LY;
         8: return ~LX;
         default: return LX;
      endcase
   endfunction
   task automatic sc_mul;
      mul_case(25'h1fffffd, 25'h000000a, 18'h3fff9, 1'b0, 48'h64, 1'b0);
      mul_case(25'h1fffffd, 25'h000000a, 18'h3fff9, 1'b1, 48'h64, 1'b1);
      mul_case(25'h0000001, 25'h0ffffff, 18'h20000, 1'b0, 48'h0, 1'b0);
   endtask
   // The old result stands until the third edge after the new operands.
   task automatic sc_byp;
      u_fabric_model.put(25'h7, 25'h9, 18'h5, LY, 48'h123456789abc,
                         mk(1'b1, 1'b0, op_sub, simd_one, lf_and));
      repeat (2) tick();
      `CHK(p_out, 48'h020000000000);
      tick();
      `CHK(p_out, LY - 48'h123456789abc);
   endtask
   task automatic sc_simd;
      go('0, '0, '0, 48'h000001000001, '1, mk(1'b1, 1'b0, op_add, simd_two, lf_and));
      `CHK(p_out, 48'h0);
      go('0, '0, '0, 48'h001001001001, '1, mk(1'b1, 1'b0, op_add, simd_four, lf_and));
      `CHK(p_out, 48'h0);
      go('0, '0, '0, 48'h0, 48'h1, mk(1'b1, 1'b0, op_sub, simd_two, lf_and));
      `CHK(p_out, 48'h000000ffffff);
      go('0, '0, '0, 48'h0, 48'h1, mk(1'b1, 1'b0, op_sub, simd_four, lf_and));
      `CHK(p_out, 48'h000000000fff);
      go('0, '0, '0, 48'h0, 48'h1, mk(1'b1, 1'b0, op_sub, simd_one, lf_and));
      `CHK(p_out, 48'hffffffffffff);
   endtask
   task automatic sc_logic;
      for (int i = 0; i < 10; i++) begin
         go('0, '0, '0, LY, LX, mk(1'b1, 1'b0, op_logic, simd_one, logic_fn_t'(i)));
         `CHK(p_out, lexp(i));
      end
   endtask
   // Product 15 is held; later ops reach the output two edges late.
   task automatic sc_acc;
      go('0, 25'h5, 18'h3, '0, '0, mk(1'b0, 1'b0, op_add, simd_one, lf_and));
      `CHK(p_out, 48'h0f);
      go('0, 25'h5, 18'h3, '0, '0, mk(1'b0, 1'b0, op_acc_add, simd_one, lf_and));
      `CHK(p_out, 48'h1e);
      tick();
      `CHK(p_out, 48'h2d);
      go('0, 25'h5, 18'h3, '0, '0, mk(1'b0, 1'b0, op_cnt_up, simd_one, lf_and));
      `CHK(p_out, 48'h4c);
      tick();
      `CHK(p_out, 48'h4d);
      go('0, 25'h5, 18'h3, '0, '0, mk(1'b0, 1'b0, op_cnt_dn, simd_one, lf_and));
      `CHK(p_out, 48'h4e);
      tick();
      `CHK(p_out, 48'h4d);
      u_fabric_model.stage(3'h6, 3'h0);
      tick();
      tick();
      `CHK(p_out, 48'h4d);
      u_fabric_model.stage(3'h6, 3'h7);
      tick();
      `CHK(p_out, 48'h0);
      u_fabric_model.stage(3'h7, 3'h0);
      // Cleared product and input stages feed zeros over the next two edges.
      tick();
      `CHK(p_out, 48'h0);
      tick();
      `CHK(p_out, 48'h0);
   endtask
   task automatic sc_pat;
      go('0, '0, '0, '0, 48'h0123456789ab, mk(1'b1, 1'b0, op_add, simd_one, lf_and));
      u_fabric_model.side(48'h0123456789ab, 48'h0, '1, 1'b0);
      #5;
      `CHK(pat, 2'b10);
      `CHK(wide_and, 1'b1);
      u_fabric_model.side(48'h0123456789aa, 48'h1, 48'hfffffffffffd, 1'b0);
      #5;
      `CHK(pat.match, 1'b1);
      `CHK(wide_and, 1'b0);
      u_fabric_model.side(~48'h0123456789ab, 48'h0, '1, 1'b0);
      #5;
      `CHK(pat, 2'b01);
   endtask
   task automatic sc_casc;
      u_fabric_model.side(48'h0, 48'h0, 48'h100000000000, 1'b1);
      go('0, '0, '0, '0, 48'h5, mk(1'b1, 1'b0, op_add, simd_one, lf_and));
      `CHK(p_out, 48'h100000000005);
      `CHK(casc_out, 48'h100000000005);
      u_fabric_model.side(48'h0, 48'h0, 48'h0, 1'b0);
   endtask
   // Cuts a hung run short.
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      final_report();
   end
   // Main sequence.
   initial begin
      error_cnt = 0;
      tests_run = 0;
      nrst = 1'b0;
      repeat (12) @(posedge clk);
      `CHK(p_out, 48'h0);
      @(negedge clk);
      nrst = 1'b1;
      sc_mul();
      sc_byp();
      sc_simd();
      sc_logic();
      sc_acc();
      sc_pat();
      sc_casc();
      final_report();
   end
endmodule
`default_nettype wire
